// file: jtag_debug_port_access.sv
/*
  Debug and programming access port: pin synchronisers, test controller,
  instruction and data scan, mailbox words to and from software, device
  reset request and port-select configuration behind an AHB-Lite slave.
  Assumes the test clock is at most a third of sys_clk_in so each of its
  levels is seen for at least one cycle after synchronisation.
*/
// Behaviour
// - Standard boundary-scan test controller with instruction and data scan.
// - Four pins normally; test reset pin acts only when enabled.
// - Port enabled from reset; ports-disabled setting frees pins as GPIO.
// - Default is 4-wire mode, reset pin off, mode-select input only.
// - Serial-wire mode once selected, switch sequence enters 4-wire scan mode.
// - Reset instruction resets device unless port-select says disabled.
// - Shared pin is reset only when no dedicated reset pin exists.
`timescale 1ns/1ps
`default_nettype none
module jtag_debug_port_access
  import jtag_dbg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_n_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic tms_out,
  output logic tms_oe_out,
  input wire logic dedicated_reset_pin_in,
  output logic shared_pin_is_reset_out,
  output logic pins_as_gpio_out,
  output logic sys_reset_req_out
);
  tap_pins_t pin_raw;
  tap_pins_t pin_s;
  tap_state_t tap_state;
  logic tck_prev_ff;
  logic tck_rise;
  logic tck_fall;
  logic port_live;
  logic jtag_rise;
  logic jtag_fall;
  logic trst_en;
  logic tap_reset;
  logic [1:0] psel_ff;
  logic cfg_touched_ff;
  logic swd_active_ff;
  logic [15:0] swd_seq_ff;
  logic [15:0] nxt_swd_seq;
  logic [3:0] ir_shift_ff;
  logic [3:0] ir_ff;
  logic [31:0] dr_ff;
  logic long_dr;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic [31:0] rx_data_ff;
  logic [31:0] tx_data_ff;
  logic rx_full_ff;
  logic tx_full_ff;
  logic rx_set;
  logic tx_take;
  logic rd_rx;
  logic tx_write;
  logic cfg_write;
  logic ahb_go;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] status_word;
  logic sys_reset_req_ff;
  logic strap_done_ff;
  logic has_rst_pin_ff;
  logic shared_pin_reset_ff;

  // pins cross into the system clock before any logic sees them
  assign pin_raw = '{tck: tck_in, tms: tms_in, tdi: tdi_in, trst_n: trst_n_in};

  sync_2ff #(.W($bits(tap_pins_t))) u_pin_sync (
    .clk_in(sys_clk_in),
    .rst_in(reset_in),
    .d_in(pin_raw),
    .q_out(pin_s)
  );

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tck_prev_ff <= 1'b0;
    end else begin
      tck_prev_ff <= pin_s.tck;
    end
  end

  assign tck_rise = pin_s.tck & ~tck_prev_ff;
  assign tck_fall = ~pin_s.tck & tck_prev_ff;
  // the ports-disabled setting releases the pins
  assign port_live = (psel_ff != PSEL_OFF);
  assign pins_as_gpio_out = ~port_live;
  assign jtag_rise = tck_rise & port_live & ~swd_active_ff;
  assign jtag_fall = tck_fall & port_live & ~swd_active_ff;
  // test reset pin counts only in five-pin mode
  assign trst_en = (psel_ff == PSEL_JTAG5);
  assign tap_reset = (trst_en & ~pin_s.trst_n) | ~port_live | swd_active_ff;

  // controller also reset by mode-select held high
  tap_controller u_tap (
    .clk_in(sys_clk_in),
    .rst_in(reset_in),
    .tck_rise_in(jtag_rise),
    .tms_in(pin_s.tms),
    .tap_reset_in(tap_reset),
    .state_out(tap_state)
  );

  // unprogrammed default: 4-wire scan, reset pin off
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      psel_ff <= PSEL_JTAG4;
      cfg_touched_ff <= 1'b0;
    end else if (cfg_write) begin
      psel_ff <= hwdata_in[CFG_PSEL_LSB +: 2];
      cfg_touched_ff <= 1'b1;
    end
  end

  // serial-wire acquisition until the switch sequence is seen
  assign nxt_swd_seq = {swd_seq_ff[14:0], pin_s.tms};
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      swd_active_ff <= 1'b0;
      swd_seq_ff <= 16'h0000;
    end else if (cfg_write) begin
      swd_active_ff <= (hwdata_in[CFG_PSEL_LSB +: 2] == PSEL_SWD);
      swd_seq_ff <= 16'h0000;
    end else if (swd_active_ff && tck_rise) begin
      swd_seq_ff <= nxt_swd_seq;
      if (nxt_swd_seq == SWD_JTAG_SEQ) begin
        swd_active_ff <= 1'b0;
      end
    end
  end

  // no serial-wire responder here; the line is only ever an input
  assign tms_out = 1'b0;
  assign tms_oe_out = 1'b0;

  // instruction register capture, shift and update
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ir_shift_ff <= IR_CAPTURE;
      ir_ff <= IR_IDCODE;
    end else if (tap_reset || tap_state == TLR) begin
      // test-logic-reset restores the identity instruction too
      ir_ff <= IR_IDCODE;
    end else if (jtag_rise && tap_state == CAP_IR) begin
      ir_shift_ff <= IR_CAPTURE;
    end else if (jtag_rise && tap_state == SH_IR) begin
      ir_shift_ff <= {pin_s.tdi, ir_shift_ff[IR_W-1:1]};
    end else if (jtag_fall && tap_state == UPD_IR) begin
      ir_ff <= ir_shift_ff;
    end
  end

  assign long_dr = (ir_ff == IR_IDCODE) | (ir_ff == IR_WRITE) | (ir_ff == IR_READ);

  // data register; bypass and reset select one bit
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dr_ff <= ZERO_WORD;
    end else if (jtag_rise && tap_state == CAP_DR) begin
      case (ir_ff)
        IR_IDCODE: dr_ff <= ID_CODE;
        IR_READ: dr_ff <= tx_data_ff;
        default: dr_ff <= ZERO_WORD;
      endcase
    end else if (jtag_rise && tap_state == SH_DR) begin
      if (long_dr) begin
        dr_ff <= {pin_s.tdi, dr_ff[31:1]};
      end else begin
        dr_ff[0] <= pin_s.tdi;
      end
    end
  end

  // reading the outgoing word at capture frees it for software
  assign tx_take = jtag_rise & (tap_state == CAP_DR) & (ir_ff == IR_READ);
  assign rx_set = jtag_fall & (tap_state == UPD_DR) & (ir_ff == IR_WRITE);

  // output changes on the falling edge so the host samples it settled
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (!port_live || swd_active_ff) begin
      tdo_oe_ff <= 1'b0;
    end else if (jtag_fall) begin
      tdo_ff <= (tap_state == SH_IR) ? ir_shift_ff[0] : dr_ff[0];
      tdo_oe_ff <= (tap_state == SH_IR) | (tap_state == SH_DR);
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;

  // device reset only while ports are not disabled
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sys_reset_req_ff <= 1'b0;
    end else begin
      sys_reset_req_ff <= jtag_fall & (tap_state == UPD_DR) & (ir_ff == IR_RESET)
                          & dr_ff[0] & (psel_ff != PSEL_OFF);
    end
  end

  assign sys_reset_req_out = sys_reset_req_ff;

  // mailbox words; a set wins over a clear (rx: hardware set, tx: software set)
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_data_ff <= ZERO_WORD;
      rx_full_ff <= 1'b0;
    end else if (rx_set) begin
      rx_data_ff <= dr_ff;
      rx_full_ff <= 1'b1;
    end else if (rd_rx) begin
      rx_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_data_ff <= ZERO_WORD;
      tx_full_ff <= 1'b0;
    end else if (tx_write) begin
      tx_data_ff <= hwdata_in;
      tx_full_ff <= 1'b1;
    end else if (tx_take) begin
      tx_full_ff <= 1'b0;
    end
  end

  // shared pin function caught once after reset release
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_done_ff <= 1'b0;
      has_rst_pin_ff <= 1'b0;
      shared_pin_reset_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      has_rst_pin_ff <= dedicated_reset_pin_in;
      shared_pin_reset_ff <= ~dedicated_reset_pin_in;
    end
  end

  assign shared_pin_is_reset_out = shared_pin_reset_ff;

  // zero-wait slave: address phase decoded, write completes in data phase
  assign ahb_go = hsel_in & hready_in & htrans_in[1];
  assign cfg_write = wr_pend_ff & (wr_addr_ff == ADDR_CONFIG);
  assign tx_write = wr_pend_ff & (wr_addr_ff == ADDR_TX);
  assign rd_rx = ahb_go & ~hwrite_in & (haddr_in[7:0] == ADDR_RX);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= ADDR_CONFIG;
    end else begin
      wr_pend_ff <= ahb_go & hwrite_in;
      wr_addr_ff <= haddr_in[7:0];
    end
  end

  always_comb begin
    status_word = ZERO_WORD;
    status_word[ST_TAP_LSB +: 4] = tap_state;
    status_word[ST_SWD_BIT] = swd_active_ff;
    status_word[ST_RXF_BIT] = rx_full_ff;
    status_word[ST_TXF_BIT] = tx_full_ff;
    status_word[ST_RSTPIN_BIT] = has_rst_pin_ff;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hrdata_ff <= ZERO_WORD;
    end else if (ahb_go && !hwrite_in) begin
      case (haddr_in[7:0])
        ADDR_CONFIG: hrdata_ff <= {ZERO_WORD[31:2], psel_ff};
        ADDR_STATUS: hrdata_ff <= status_word;
        ADDR_RX: hrdata_ff <= rx_data_ff;
        ADDR_TX: hrdata_ff <= tx_data_ff;
        default: hrdata_ff <= ZERO_WORD;
      endcase
    end
  end

  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_reset_gate: assert property (
    sys_reset_req_ff |-> $past(psel_ff) != PSEL_OFF)
    else $error("device reset raised while ports disabled");
  a_reset_pulse: assert property (
    $rose(sys_reset_req_ff) |=> !sys_reset_req_ff)
    else $error("device reset request longer than one cycle");
  a_port_off: assert property (
    (psel_ff == PSEL_OFF) |-> pins_as_gpio_out ##1 !tdo_oe_out)
    else $error("disabled port still drives its pins");
  a_default_mode: assert property (
    !cfg_touched_ff |-> (psel_ff == PSEL_JTAG4) && !swd_active_ff && !trst_en)
    else $error("default mode is not 4-wire scan");
  a_trst_ignored: assert property (
    (!trst_en && !pin_s.trst_n && tap_state == RTI && !jtag_rise && port_live
     && !swd_active_ff) |=> tap_state == RTI)
    else $error("controller left idle without a clock edge");
  a_swd_switch: assert property (
    (swd_active_ff && tck_rise && !cfg_write && nxt_swd_seq == SWD_JTAG_SEQ)
    |=> !swd_active_ff ##1 !tms_oe_out)
    else $error("switch sequence did not enter scan mode");
  a_rx_set: assert property (
    rx_set |=> rx_full_ff && rx_data_ff == $past(dr_ff))
    else $error("scanned word not delivered to software");
  a_tx_take: assert property (
    (tx_take && !tx_write) |=> !tx_full_ff && dr_ff == $past(tx_data_ff))
    else $error("outgoing word not taken at capture");
  a_idcode: assert property (
    (jtag_rise && tap_state == CAP_DR && ir_ff == IR_IDCODE) |=> dr_ff == ID_CODE)
    else $error("identity word not captured");
  a_strap: assert property (
    $rose(strap_done_ff) |-> shared_pin_is_reset_out == !$past(dedicated_reset_pin_in))
    else $error("shared pin function disagrees with strap");
endmodule // jtag_debug_port_access
`default_nettype wire

// file: jtag_dbg_pkg.sv
/*
  Shared constants and types for the debug access port: register map,
  field positions, port-select encodings, instruction codes and the
  test-controller state type.
  Assumes a 32-bit AHB-Lite register bus and a 4-bit instruction register.
*/
`default_nettype none
package jtag_dbg_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RX = 8'h08;
  localparam logic [7:0] ADDR_TX = 8'h0C;
  // field positions
  localparam int CFG_PSEL_LSB = 0;
  localparam int ST_TAP_LSB = 0;
  localparam int ST_SWD_BIT = 4;
  localparam int ST_RXF_BIT = 5;
  localparam int ST_TXF_BIT = 6;
  localparam int ST_RSTPIN_BIT = 7;
  // debug_port_select encodings, held in the config latches
  localparam logic [1:0] PSEL_JTAG4 = 2'h0;
  localparam logic [1:0] PSEL_JTAG5 = 2'h1;
  localparam logic [1:0] PSEL_SWD = 2'h2;
  localparam logic [1:0] PSEL_OFF = 2'h3;
  // instructions
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_WRITE = 4'h2;
  localparam logic [3:0] IR_READ = 4'h3;
  localparam logic [3:0] IR_RESET = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  // identity value is arbitrary
  localparam logic [31:0] ID_CODE = 32'h1234_5671;
  // sequence on the mode-select line that leaves the serial-wire mode
  localparam logic [15:0] SWD_JTAG_SEQ = 16'hE73C;
  localparam logic [2:0] TLR_ONES = 3'h5;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_t;

  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
    SH_DR = 4'h6, EX1_DR = 4'h7, UPD_DR = 4'h5, PAU_DR = 4'h4,
    EX2_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SH_IR = 4'hE,
    EX1_IR = 4'hA, UPD_IR = 4'hB, PAU_IR = 4'h9, EX2_IR = 4'h8
  } tap_state_t;
endpackage
`default_nettype wire

// file: sync_2ff.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are slow levels relative to the sampling clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule // sync_2ff
`default_nettype wire

// file: tap_controller.sv
/*
  Sixteen-state test access controller, stepped by a one-cycle pulse
  marking each rising test-clock edge.
  Assumes tck_rise_in and tms_in are already in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_controller
  import jtag_dbg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tck_rise_in,
  input wire logic tms_in,
  input wire logic tap_reset_in,
  output tap_state_t state_out
);
  tap_state_t state_ff;
  tap_state_t nxt_state;
  logic [2:0] ones_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TLR: nxt_state = tms_in ? TLR : RTI;
      RTI: nxt_state = tms_in ? SEL_DR : RTI;
      SEL_DR: nxt_state = tms_in ? SEL_IR : CAP_DR;
      CAP_DR: nxt_state = tms_in ? EX1_DR : SH_DR;
      SH_DR: nxt_state = tms_in ? EX1_DR : SH_DR;
      EX1_DR: nxt_state = tms_in ? UPD_DR : PAU_DR;
      PAU_DR: nxt_state = tms_in ? EX2_DR : PAU_DR;
      EX2_DR: nxt_state = tms_in ? UPD_DR : SH_DR;
      UPD_DR: nxt_state = tms_in ? SEL_DR : RTI;
      SEL_IR: nxt_state = tms_in ? TLR : CAP_IR;
      CAP_IR: nxt_state = tms_in ? EX1_IR : SH_IR;
      SH_IR: nxt_state = tms_in ? EX1_IR : SH_IR;
      EX1_IR: nxt_state = tms_in ? UPD_IR : PAU_IR;
      PAU_IR: nxt_state = tms_in ? EX2_IR : PAU_IR;
      EX2_IR: nxt_state = tms_in ? UPD_IR : SH_IR;
      UPD_IR: nxt_state = tms_in ? SEL_DR : RTI;
      default: nxt_state = TLR;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= TLR;
    end else if (tap_reset_in) begin
      state_ff <= TLR;
    end else if (tck_rise_in) begin
      state_ff <= nxt_state;
    end
  end

  // helper: consecutive high mode-select samples, saturating
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ones_ff <= 3'h0;
    end else if (tck_rise_in && !tap_reset_in) begin
      if (!tms_in) begin
        ones_ff <= 3'h0;
      end else if (ones_ff != TLR_ONES) begin
        ones_ff <= ones_ff + 3'h1;
      end
    end
  end

  assign state_out = state_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_five_ones: assert property (
    (ones_ff == TLR_ONES) |-> (state_ff == TLR))
    else $error("five high mode-select edges did not reach reset state");
endmodule // tap_controller
`default_nettype wire

// file: jtag_host_model.sv
/*
  Host programmer model: drives the test clock, mode select, data in and
  test reset pins, and samples test data out.
  Assumes the device samples its pins with a much faster system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in,
  output logic [31:0] res_out,
  output logic res_stb_out
);
  // clock rate limit
  // 400 ns period stays under 14 MHz and a fifth of the 20 MHz clock
  localparam time HALF = 200;
  // pin edges kept clear of the system clock edge to avoid a sampling race
  localparam time SKEW = 10;

  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    trst_n_out = 1'b1;
    res_out = 32'h0000_0000;
    res_stb_out = 1'b0;
  end

  // data out is read late in the high phase, the synchroniser delays it past the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #HALF tck_out = 1'b1;
    #HALF tdo = tdo_oe_in ? tdo_in : 1'bx;
    tck_out = 1'b0;
  endtask

  task automatic tap_reset();
    logic t;
    #SKEW;
    repeat (5) step(1'b1, tdi_out, t);
    step(1'b0, tdi_out, t);
  endtask

  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic chk);
    logic t;
    logic [31:0] dout;
    #SKEW;
    dout = 32'h0000_0000;
    step(1'b1, tdi_out, t);
    if (ir) step(1'b1, tdi_out, t);
    step(1'b0, tdi_out, t);
    step(1'b0, tdi_out, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, tdi_out, t);
    step(1'b0, tdi_out, t);
    // a released data line does not keep its last level
    tdi_out = ~tdi_out;
    res_out = dout;
    if (chk) begin
      res_stb_out = 1'b1;
      #1 res_stb_out = 1'b0;
    end
  endtask

  task automatic swd_switch(input logic [15:0] seq);
    logic t;
    #SKEW;
    for (int i = 15; i >= 0; i--) step(seq[i], tdi_out, t);
  endtask

  task automatic trst_pulse();
    #SKEW;
    trst_n_out = 1'b0;
    #(2 * HALF) trst_n_out = 1'b1;
    #(2 * HALF);
  endtask
endmodule // jtag_host_model
`default_nettype wire

// file: jtag_debug_port_access_test.sv
/*
  Self-checking bench for the debug access port: AHB-Lite master tasks,
  a host programmer model on the test pins, queued expectations.
  Assumes a zero-wait slave and a host clock far below the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define chk_eq(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module jtag_debug_port_access_test
  import jtag_dbg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_r = 1'b1;
  logic strap = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rd_phase = 1'b0;
  logic probe_stb = 1'b0;
  logic [1:0] probe_sel = 2'h0;
  wire logic [31:0] hrdata, res;
  wire logic hreadyout, hresp, tck, tms, tdi, trst_n, tdo, tdo_oe, tms_o, tms_oe;
  wire logic shared_rst, gpio, sys_rst_req, res_stb;
  int bad_count = 0;
  int n_compared = 0;
  int pulses = 0;
  int cyc = 0;
  integer seed;
  logic [31:0] w1, w2, e, obs;
  logic [31:0] q_rd[$];
  logic [31:0] q_scan[$];
  logic [31:0] q_pr[$];

  always #25 sys_clk = ~sys_clk;

  jtag_debug_port_access u_dut (.sys_clk_in(sys_clk), .reset_in(reset_r), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .tms_out(tms_o),
    .tms_oe_out(tms_oe), .dedicated_reset_pin_in(strap), .shared_pin_is_reset_out(shared_rst),
    .pins_as_gpio_out(gpio), .sys_reset_req_out(sys_rst_req));

  jtag_host_model u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
    .tdo_in(tdo), .tdo_oe_in(tdo_oe), .res_out(res), .res_stb_out(res_stb));

  task automatic test_done();
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one zero-wait slave, so its ready is the bus ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wr ? d : $random(seed);
    rd_phase <= !wr;
    if (!wr) q_rd.push_back(d);
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd_phase <= 1'b0;
  endtask

  task automatic probe(input logic [1:0] sel, input logic [31:0] x);
    q_pr.push_back(x);
    probe_sel <= sel;
    probe_stb <= 1'b1;
    @(posedge sys_clk);
    probe_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  // pin levels need a few cycles through the synchroniser
  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic hscan(input logic ir, input int n, input logic [31:0] din,
                       input logic [31:0] x, input logic chk);
    if (chk) q_scan.push_back(x);
    u_host.scan(ir, n, din, chk);
    settle();
  endtask

  task automatic do_reset(input logic s);
    reset_r <= 1'b1;
    strap <= s;
    repeat (5) @(posedge sys_clk);
    reset_r <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] st(logic s, logic tx, logic rx, logic sw, logic [3:0] tap);
    return {24'h00_0000, s, tx, rx, sw, tap};
  endfunction

  always @(posedge sys_clk) begin
    if (sys_rst_req === 1'b1) pulses <= pulses + 1;
    if (rd_phase && hreadyout === 1'b1) begin
      e = q_rd.pop_front();
      `chk_eq("hrdata", e, hrdata)
      `chk_eq("hresp", 1'b0, hresp)
    end
    if (probe_stb) begin
      e = q_pr.pop_front();
      case (probe_sel)
        2'h0: obs = {31'h0, gpio};
        2'h1: obs = {31'h0, shared_rst};
        2'h2: obs = 32'(pulses);
        default: obs = {29'h0, tms_o, tms_oe, tdo_oe};
      endcase
      `chk_eq("probe", e, obs)
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  always @(posedge res_stb) begin
    e = q_scan.pop_front();
    `chk_eq("scan", e, res)
  end

  initial begin
    seed = 32'hd7889188;
    w1 = $random(seed);
    w2 = $random(seed);
    do_reset(1'b1);
    probe(2'h1, 32'h0);
    probe(2'h0, 32'h0);
    probe(2'h3, 32'h0);
    ahb(1'b0, ADDR_CONFIG, 32'(PSEL_JTAG4));
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, TLR));
    ahb(1'b1, 8'h10, w1);
    ahb(1'b0, 8'h10, ZERO_WORD);
    u_host.tap_reset();
    settle();
    hscan(1'b0, 32, w2, ID_CODE, 1'b1);
    hscan(1'b1, IR_W, 32'(IR_BYPASS), 32'h1, 1'b1);
    hscan(1'b0, 2, 32'h3, 32'h2, 1'b1);
    // scan word into the mailbox, then read it over the bus
    hscan(1'b1, IR_W, 32'(IR_WRITE), 32'h1, 1'b1);
    hscan(1'b0, 32, w1, ZERO_WORD, 1'b0);
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b1, 1'b0, RTI));
    ahb(1'b0, ADDR_RX, w1);
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, RTI));
    ahb(1'b1, ADDR_TX, w2);
    ahb(1'b0, ADDR_TX, w2);
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b1, 1'b0, 1'b0, RTI));
    hscan(1'b1, IR_W, 32'(IR_READ), 32'h1, 1'b1);
    hscan(1'b0, 32, w1, w2, 1'b1);
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, RTI));
    hscan(1'b1, IR_W, 32'(IR_RESET), 32'h1, 1'b1);
    hscan(1'b0, 1, 32'h1, ZERO_WORD, 1'b0);
    probe(2'h2, 32'h1);
    // mode-select reset brings the identity instruction back
    u_host.tap_reset();
    hscan(1'b0, 32, w2, ID_CODE, 1'b1);
    // test reset pin is ignored until the five-pin mode is chosen
    u_host.trst_pulse();
    settle();
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, RTI));
    ahb(1'b1, ADDR_CONFIG, 32'(PSEL_JTAG5));
    ahb(1'b0, ADDR_CONFIG, 32'(PSEL_JTAG5));
    u_host.trst_pulse();
    settle();
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, TLR));
    ahb(1'b1, ADDR_CONFIG, 32'(PSEL_SWD));
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b1, TLR));
    probe(2'h3, 32'h0);
    u_host.swd_switch(SWD_JTAG_SEQ);
    settle();
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, TLR));
    u_host.tap_reset();
    hscan(1'b0, 32, w1, ID_CODE, 1'b1);
    // ports disabled: pins freed and the reset instruction has no effect
    ahb(1'b1, ADDR_CONFIG, 32'(PSEL_OFF));
    probe(2'h0, 32'h1);
    hscan(1'b1, IR_W, 32'(IR_RESET), ZERO_WORD, 1'b0);
    hscan(1'b0, 1, 32'h1, ZERO_WORD, 1'b0);
    probe(2'h2, 32'h1);
    ahb(1'b1, ADDR_CONFIG, 32'(PSEL_JTAG4));
    probe(2'h0, 32'h0);
    ahb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    ahb(1'b0, ADDR_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0, TLR));
    // second reset in mid-run with the other strap level
    do_reset(1'b0);
    probe(2'h1, 32'h1);
    ahb(1'b0, ADDR_STATUS, st(1'b0, 1'b0, 1'b0, 1'b0, TLR));
    ahb(1'b0, ADDR_CONFIG, 32'(PSEL_JTAG4));
    repeat (3) @(posedge sys_clk);
    test_done();
  end
endmodule // jtag_debug_port_access_test
`default_nettype wire
